// ==== logic/iocl_map.svh ====
// Purpose: named constants of the io copy telemetry link
// Assumes: 100 MHz clock
// Notes:   definitions only
`ifndef IOCL_MAP_SVH
`define IOCL_MAP_SVH
`define IOCL_CLK_PERIOD_NS  10
`define IOCL_MS_NS          1000000
`define IOCL_CYC_PER_MS     (`IOCL_MS_NS / `IOCL_CLK_PERIOD_NS)
`define IOCL_MS_PER_S       1000
`define IOCL_MS_PER_S_LAST  10'h3e7
`define IOCL_REFRESH_MIN_MS 16'h0064
`define IOCL_REFRESH_MAX_MS 16'hfde8
`define IOCL_ROLE_SERVER    2'h1
`define IOCL_ROLE_CLIENT    2'h2
`define IOCL_NSLOT          9
`define IOCL_IO4            3
`define IOCL_CH_SEP         8'h54
`define IOCL_CH_DIG         8'h44
`define IOCL_CH_REPLY       8'h52
`define IOCL_CH_ERR         8'h45
`define IOCL_CH_CR          8'h0d
`define IOCL_CH_TWO         8'h32
`define IOCL_CH_FIVE        8'h35
`define IOCL_FRM_VLO        3'h5
`define IOCL_FRM_PER        3'h6
`define IOCL_FRM_LAST       3'h7
`define IOCL_FAIL_LAST      3'h6
`endif

// ==== logic/iocl_pkg.sv ====
// Purpose: shared types of the io copy telemetry link
// Assumes: nothing
// Notes:   frame sequencer states, gray along idle-send-wait
package iocl_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_send = 2'h1,
        st_wait = 2'h3
    } iocl_state_t;
endpackage

// ==== logic/iocl_top.sv ====
// Purpose: io mirroring client/server with link supervision and routing
// Assumes: radio frames arrive pre-parsed; serial bytes are synchronous
// Notes:   numeric header frame form, one byte per address
`timescale 1ns/1ps
`include "iocl_map.svh"

module iocl_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    logic [W-1:0] head_q;
    logic [W-1:0] skid_q;
    logic         head_v_q;
    logic         skid_v_q;
    wire          push      = in_valid & ~skid_v_q;
    wire          head_free = ~head_v_q | out_ready;

    assign in_ready  = ~skid_v_q;
    assign out_valid = head_v_q;
    assign out_data  = head_q;

    // skid slot keeps a word when the receiver stalls in the push cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            head_q   <= '0;
            skid_q   <= '0;
            head_v_q <= 1'b0;
            skid_v_q <= 1'b0;
        end else if (head_free) begin
            if (skid_v_q) begin
                head_q   <= skid_q;
                head_v_q <= 1'b1;
                skid_v_q <= 1'b0;
            end else begin
                head_q   <= in_data;
                head_v_q <= push;
            end
        end else if (push) begin
            skid_q   <= in_data;
            skid_v_q <= 1'b1;
        end
    end
endmodule

module iocl_watch (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       sec_tick,
    input  wire logic       seen,
    input  wire logic       take,
    input  wire logic [7:0] src,
    input  wire logic [7:0] period_s,
    output logic            used,
    output logic            hit,
    output logic            expired
);
    logic [7:0] addr_q;
    logic [7:0] per_q;
    logic [8:0] cnt_q;
    logic       used_q;
    logic       fired_q;
    logic       exp_q;
    wire        arm   = seen & (hit | take);
    wire  [8:0] limit = {per_q, 1'b1};
    // fires on the tick after limit whole seconds: up to one second late, never early
    wire        due   = sec_tick & used_q & ~fired_q & (cnt_q >= limit);

    assign used    = used_q;
    assign hit     = used_q & (addr_q == src);
    assign expired = exp_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            addr_q  <= 8'h00;
            per_q   <= 8'h00;
            cnt_q   <= 9'h000;
            used_q  <= 1'b0;
            fired_q <= 1'b0;
            exp_q   <= 1'b0;
        end else begin
            exp_q <= due & ~arm;
            if (arm) begin
                addr_q  <= src;
                per_q   <= period_s;
                used_q  <= 1'b1;
                cnt_q   <= 9'h000;
                fired_q <= 1'b0;
            end else if (due) begin
                fired_q <= 1'b1;
            end else if (sec_tick && used_q && !fired_q) begin
                cnt_q <= cnt_q + 9'h1;
            end
        end
    end
endmodule

module iocl_top
    import iocl_pkg::*;
#(
    parameter int CYC_PER_MS = `IOCL_CYC_PER_MS
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [1:0]  mirror_role_select,
    input  wire logic [7:0]  own_address,
    input  wire logic [7:0]  default_telemetry_peer,
    input  wire logic [7:0]  default_data_peer,
    input  wire logic [15:0] refresh_period_setting,
    input  wire logic        low_power_select,
    input  wire logic [8:0]  io_in,
    input  wire logic [8:0]  edge_enable,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_src,
    input  wire logic        rx_reply,
    input  wire logic        rx_edge_io4,
    input  wire logic [8:0]  rx_values,
    input  wire logic [7:0]  rx_period_s,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [7:0]  tx_data,
    output logic      [7:0]  tx_peer,
    output logic             tx_last,
    input  wire logic        ser_rx_valid,
    input  wire logic [7:0]  ser_rx_data,
    output logic             ser_tx_valid,
    input  wire logic        ser_tx_ready,
    output logic      [7:0]  ser_tx_data,
    output logic             data_tx_valid,
    output logic      [7:0]  data_tx_data,
    output logic      [7:0]  data_tx_peer,
    output logic             order_valid,
    output logic      [7:0]  order_data,
    output logic      [8:0]  io_out,
    output logic             ack_tx,
    output logic             standby,
    output logic      [8:0]  link_fail
);
    localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);

    iocl_state_t st_q;
    logic [16:0] div_q;
    logic [9:0]  ms_q;
    logic [15:0] ref_q;
    logic [8:0]  prev_q;
    logic        edge_ok_q;
    logic        due_pend_q;
    logic        edge_pend_q;
    logic        rep_pend_q;
    logic [7:0]  rep_src_q;
    logic [2:0]  idx_q;
    logic [7:0]  frm_peer_q;
    logic [8:0]  frm_vals_q;
    logic        frm_client_q;
    logic [8:0]  io_out_q;
    logic        standby_q;
    logic [8:0]  fail_pend_q;
    logic [8:0]  link_fail_q;
    logic        fs_act_q;
    logic [2:0]  fs_idx_q;
    logic        ser_v_q;
    logic [7:0]  ser_d_q;
    logic        ack_q;
    logic        dtx_v_q;
    logic [7:0]  dtx_d_q;
    logic [7:0]  dtx_p_q;
    logic        ord_v_q;
    logic [7:0]  ord_d_q;
    logic [8:0]  alloc_sel;
    logic        found;
    logic [7:0]  frm_byte;
    logic [7:0]  fail_byte;
    logic [8:0]  hit;
    logic [8:0]  used;
    logic [8:0]  expired;
    logic        buf_in_ready;

    // role decode
    wire        is_server = mirror_role_select == `IOCL_ROLE_SERVER;
    wire        is_client = mirror_role_select == `IOCL_ROLE_CLIENT;

    wire        ms_tick  = div_q == MS_LAST;
    wire        sec_tick = ms_tick & (ms_q == `IOCL_MS_PER_S_LAST);

    // period clamp and its figure in whole seconds, rounded up
    wire [15:0] per_ms = (refresh_period_setting < `IOCL_REFRESH_MIN_MS) ?
                         `IOCL_REFRESH_MIN_MS :
                         (refresh_period_setting > `IOCL_REFRESH_MAX_MS) ?
                         `IOCL_REFRESH_MAX_MS : refresh_period_setting;
    wire [7:0]  per_s  = 8'((32'(per_ms) + `IOCL_MS_PER_S - 1) / `IOCL_MS_PER_S);
    wire        due    = is_client & ms_tick & (ref_q + 16'h1 >= per_ms);
    // prev_q has not seen the pins in the first cycle after reset: no false edge then
    wire [8:0]  edges  = (io_in ^ prev_q) & edge_enable & {9{edge_ok_q}};

    // a client may restart from wait: a lost reply must not stall it
    wire start_client = is_client & (st_q != st_send) &
                        (due_pend_q | edge_pend_q);
    wire start_server = is_server & (st_q == st_idle) & rep_pend_q;
    wire start        = start_client | start_server;

    wire new_frame  = rx_valid & ~rx_reply & is_server;
    wire reply_in   = rx_valid & rx_reply & is_client & (st_q == st_wait);
    wire any_hit    = |hit;
    wire byte_go    = (st_q == st_send) & buf_in_ready;
    wire frm_end    = byte_go & (idx_q == `IOCL_FRM_LAST);
    wire [2:0] idx_nx = (idx_q == `IOCL_FRM_VLO && !frm_client_q) ?
                        `IOCL_FRM_LAST : idx_q + 3'h1;

    wire [8:0] fail_pick = fail_pend_q & (~fail_pend_q + 9'h1);
    wire       fs_start  = ~fs_act_q & (|fail_pend_q);
    wire       ser_adv   = ~ser_v_q | ser_tx_ready;
    wire       ser_data  = default_data_peer != 8'h00;

    // frame bytes in digital read reply form
    always_comb begin
        case (idx_q)
            3'h0:          frm_byte = own_address;
            3'h1:          frm_byte = `IOCL_CH_SEP;
            3'h2:          frm_byte = `IOCL_CH_DIG;
            3'h3:          frm_byte = `IOCL_CH_REPLY;
            3'h4:          frm_byte = {7'h00, frm_vals_q[8]};
            `IOCL_FRM_VLO: frm_byte = frm_vals_q[7:0];
            `IOCL_FRM_PER: frm_byte = per_s;
            default:       frm_byte = `IOCL_CH_CR;
        endcase
    end

    // failure string on the serial link
    always_comb begin
        case (fs_idx_q)
            3'h0:    fail_byte = `IOCL_CH_TWO;
            3'h1:    fail_byte = `IOCL_CH_FIVE;
            3'h2:    fail_byte = `IOCL_CH_FIVE;
            3'h3:    fail_byte = `IOCL_CH_SEP;
            3'h4:    fail_byte = `IOCL_CH_DIG;
            3'h5:    fail_byte = `IOCL_CH_ERR;
            default: fail_byte = `IOCL_CH_CR;
        endcase
    end

    // first free slot; clients past the ninth are never tracked
    always_comb begin
        alloc_sel = 9'h000;
        found     = 1'b0;
        for (int i = 0; i < `IOCL_NSLOT; i++) begin
            if (!used[i] && !found) begin
                alloc_sel[i] = 1'b1;
                found        = 1'b1;
            end
        end
    end

    for (genvar g = 0; g < `IOCL_NSLOT; g++) begin : g_slot
        iocl_watch u_watch (
            .clock    (clock),
            .nrst     (nrst),
            .sec_tick (sec_tick),
            .seen     (new_frame),
            .take     (alloc_sel[g] & ~any_hit),
            .src      (rx_src),
            .period_s (rx_period_s),
            .used     (used[g]),
            .hit      (hit[g]),
            .expired  (expired[g])
        );
    end

    iocl_buf2 #(.W(17)) u_txbuf (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (st_q == st_send),
        .in_ready  (buf_in_ready),
        .in_data   ({idx_q == `IOCL_FRM_LAST, frm_peer_q, frm_byte}),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  ({tx_last, tx_peer, tx_data})
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_q <= 17'h00000;
            ms_q  <= 10'h000;
            ref_q <= 16'h0000;
        end else begin
            div_q <= ms_tick ? 17'h00000 : div_q + 17'h1;
            if (ms_tick) begin
                ms_q  <= sec_tick ? 10'h000 : ms_q + 10'h1;
                ref_q <= (due || !is_client) ? 16'h0000 : ref_q + 16'h1;
            end
        end
    end

    // pending flags: a new event in the clearing cycle wins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_q      <= 9'h000;
            edge_ok_q   <= 1'b0;
            due_pend_q  <= 1'b0;
            edge_pend_q <= 1'b0;
            rep_pend_q  <= 1'b0;
            rep_src_q   <= 8'h00;
        end else begin
            prev_q      <= io_in;
            edge_ok_q   <= 1'b1;
            due_pend_q  <= due | (due_pend_q & ~start_client);
            edge_pend_q <= (is_client & (|edges)) |
                           (edge_pend_q & ~start_client);
            rep_pend_q  <= new_frame | (rep_pend_q & ~start_server);
            if (new_frame)
                rep_src_q <= rx_src;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q         <= st_idle;
            idx_q        <= 3'h0;
            frm_peer_q   <= 8'h00;
            frm_vals_q   <= 9'h000;
            frm_client_q <= 1'b0;
        end else begin
            case (st_q)
                st_idle, st_wait: begin
                    if (start) begin
                        st_q         <= st_send;
                        idx_q        <= 3'h0;
                        frm_vals_q   <= io_in;
                        frm_client_q <= start_client;
                        frm_peer_q   <= start_client ? default_telemetry_peer
                                                     : rep_src_q;
                    end else if (reply_in || !is_client) begin
                        st_q <= st_idle;
                    end
                end
                st_send: begin
                    if (frm_end)
                        st_q <= frm_client_q ? st_wait : st_idle;
                    if (byte_go)
                        idx_q <= idx_nx;
                end
                default: st_q <= st_idle;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            io_out_q  <= 9'h000;
            standby_q <= 1'b0;
        end else begin
            if (reply_in)
                io_out_q <= rx_values;
            else if (new_frame)
                io_out_q <= rx_edge_io4 ? rx_values & ~(9'h001 << `IOCL_IO4)
                                        : rx_values;
            standby_q <= low_power_select & is_client & (st_q == st_idle) &
                         ~due_pend_q & ~edge_pend_q & ~due;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fail_pend_q <= 9'h000;
            link_fail_q <= 9'h000;
            fs_act_q    <= 1'b0;
            fs_idx_q    <= 3'h0;
            ser_v_q     <= 1'b0;
            ser_d_q     <= 8'h00;
            ack_q       <= 1'b0;
        end else begin
            fail_pend_q <= expired | (fail_pend_q & ~(fs_start ? fail_pick : 9'h000));
            link_fail_q <= expired | (link_fail_q & ~(new_frame ? hit : 9'h000));
            ack_q       <= fs_start;
            if (fs_start) begin
                fs_act_q <= 1'b1;
                fs_idx_q <= 3'h0;
            end else if (fs_act_q && ser_adv) begin
                fs_idx_q <= fs_idx_q + 3'h1;
                if (fs_idx_q == `IOCL_FAIL_LAST)
                    fs_act_q <= 1'b0;
            end
            if (ser_adv) begin
                ser_v_q <= fs_act_q;
                ser_d_q <= fail_byte;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dtx_v_q <= 1'b0;
            dtx_d_q <= 8'h00;
            dtx_p_q <= 8'h00;
            ord_v_q <= 1'b0;
            ord_d_q <= 8'h00;
        end else begin
            dtx_v_q <= ser_rx_valid & ser_data;
            ord_v_q <= ser_rx_valid & ~ser_data;
            dtx_d_q <= ser_rx_data;
            ord_d_q <= ser_rx_data;
            dtx_p_q <= default_data_peer;
        end
    end

    assign io_out        = io_out_q;
    assign standby       = standby_q;
    assign link_fail     = link_fail_q;
    assign ack_tx        = ack_q;
    assign ser_tx_valid  = ser_v_q;
    assign ser_tx_data   = ser_d_q;
    assign data_tx_valid = dtx_v_q;
    assign data_tx_data  = dtx_d_q;
    assign data_tx_peer  = dtx_p_q;
    assign order_valid   = ord_v_q;
    assign order_data    = ord_d_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_fail_start;
        $rose(fs_act_q);
    endsequence
    sequence s_ack_pulse;
        ack_tx ##1 !ack_tx;
    endsequence

    property p_srv_quiet;
        is_server && st_q == st_idle && !rep_pend_q |=> st_q != st_send;
    endproperty
    a_srv_quiet: assert property (p_srv_quiet) else $error("server sent unasked");
    property p_reply_out;
        reply_in |=> io_out == $past(rx_values);
    endproperty
    a_reply_out: assert property (p_reply_out) else $error("reply not applied");
    property p_edge_send;
        is_client && (|edges) && st_q == st_idle |-> ##[1:2] st_q == st_send;
    endproperty
    a_edge_send: assert property (p_edge_send) else $error("edge not sent");
    property p_per_byte;
        byte_go && idx_q == `IOCL_FRM_PER |->
            32'(frm_byte) * `IOCL_MS_PER_S >= 32'(per_ms);
    endproperty
    a_per_byte: assert property (p_per_byte) else $error("bad period byte");
    property p_standby;
        standby |-> $past(low_power_select) && $past(st_q) == st_idle;
    endproperty
    a_standby: assert property (p_standby) else $error("standby while busy");
    property p_fail_ack;
        s_fail_start |-> s_ack_pulse;
    endproperty
    a_fail_ack: assert property (p_fail_ack) else $error("no ack edge");
    property p_io4_low;
        new_frame && rx_edge_io4 |=> !io_out[`IOCL_IO4];
    endproperty
    a_io4_low: assert property (p_io4_low) else $error("fourth output high");
    property p_data_route;
        ser_rx_valid && ser_data |=> data_tx_valid && !order_valid &&
            data_tx_peer == $past(default_data_peer);
    endproperty
    a_data_route: assert property (p_data_route) else $error("data misrouted");
    property p_tele_peer;
        start_client |=> frm_peer_q == $past(default_telemetry_peer);
    endproperty
    a_tele_peer: assert property (p_tele_peer) else $error("wrong peer");
    property p_frame_cr;
        tx_valid && tx_last |-> tx_data == `IOCL_CH_CR;
    endproperty
    a_frame_cr: assert property (p_frame_cr) else $error("frame not ended");
endmodule

// ==== bench/iocl_peer.sv ====
// Purpose: radio peer model, takes frames from the link and hands it parsed ones
// Assumes: one parsed frame per call of send
// Notes:   slow makes the peer refuse every other cycle
`timescale 1ns/1ps
module iocl_peer (
    input  wire logic       clock,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic [7:0] tx_peer,
    input  wire logic       tx_last,
    output logic            tx_ready = 1'b1,
    output logic            rx_valid = 1'b0,
    output logic      [7:0] rx_src = 8'h00,
    output logic            rx_reply = 1'b0,
    output logic            rx_edge_io4 = 1'b0,
    output logic      [8:0] rx_values = 9'h000,
    output logic      [7:0] rx_period_s = 8'h00
);
    logic [7:0] got[$];
    logic [7:0] dest[$];
    int         frames = 0;
    // stalling backs the buffer up; no byte may be lost
    always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clock) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            dest.push_back(tx_peer);
            if (tx_last)
                frames++;
        end
    end
    // fields are scrambled after the pulse so stale values cannot pass
    task automatic send(input logic rep, input logic [7:0] src, input logic [8:0] v,
                        input logic [7:0] per, input logic e4);
        @(negedge clock);
        rx_valid <= 1'b1;
        rx_reply <= rep;
        rx_src <= src;
        rx_values <= v;
        rx_period_s <= per;
        rx_edge_io4 <= e4;
        @(negedge clock);
        rx_valid <= 1'b0;
        rx_src <= ~src;
        rx_values <= ~v;
        rx_period_s <= ~per;
        rx_edge_io4 <= ~e4;
    endtask
endmodule

// ==== bench/io_copy_telemetry_link_test.sv ====
// Purpose: self-checking bench of the io copy telemetry link
// Assumes: CYC_PER_MS set to 10, so one second is 10000 cycles
// Notes:   serial routing as table rows, client and server flows by hand
`timescale 1ns/1ps
`include "iocl_map.svh"
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("unexpected t=%0t got %h exp %h", $time, g, e); \
    end \
end
module io_copy_telemetry_link_test;
    typedef struct {logic [7:0] pe; logic [7:0] b; logic dv;} iocl_row_t;
    logic        clock = 1'b0, nrst = 1'b0, lp = 1'b0, srv = 1'b0, srr = 1'b1, slow = 1'b0;
    logic [1:0]  role = 2'h0;
    logic [7:0]  own = 8'h11, tele = 8'h33, dpeer = 8'h00, srd = 8'h00;
    logic [15:0] refr = 16'h0064;
    logic [8:0]  io_in = 9'h102, een = 9'h001;
    logic        tx_valid, tx_ready, tx_last, rx_valid, rx_reply, rx_e4, ser_tx_valid;
    logic        data_tx_valid, order_valid, ack_tx, standby;
    logic [7:0]  tx_data, tx_peer, rx_src, rx_per, ser_tx_data, data_tx_data, data_tx_peer;
    logic [7:0]  order_data;
    logic [8:0]  rx_values, io_out, link_fail;
    logic [7:0]  ser[$], e[$];
    int          err_total = 0, total_checks = 0, acks = 0, k;
    iocl_row_t   rows[4] = '{'{8'h00, 8'h47, 1'b0}, '{8'h3c, 8'h47, 1'b1},
                             '{8'h3c, 8'h0d, 1'b1}, '{8'h00, 8'h0d, 1'b0}};

    always #5 clock = ~clock;
    // the serial sink stalls every other cycle
    always @(negedge clock) srr <= ~srr;
    always @(posedge clock) begin
        if (ser_tx_valid && srr)
            ser.push_back(ser_tx_data);
        if (ack_tx)
            acks++;
    end

    iocl_top #(.CYC_PER_MS(10)) dut_u (
        .clock(clock), .nrst(nrst), .mirror_role_select(role), .own_address(own),
        .default_telemetry_peer(tele), .default_data_peer(dpeer),
        .refresh_period_setting(refr), .low_power_select(lp), .io_in(io_in),
        .edge_enable(een), .rx_valid(rx_valid), .rx_src(rx_src), .rx_reply(rx_reply),
        .rx_edge_io4(rx_e4), .rx_values(rx_values), .rx_period_s(rx_per),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_peer(tx_peer),
        .tx_last(tx_last), .ser_rx_valid(srv), .ser_rx_data(srd),
        .ser_tx_valid(ser_tx_valid), .ser_tx_ready(srr), .ser_tx_data(ser_tx_data),
        .data_tx_valid(data_tx_valid), .data_tx_data(data_tx_data),
        .data_tx_peer(data_tx_peer), .order_valid(order_valid), .order_data(order_data),
        .io_out(io_out), .ack_tx(ack_tx), .standby(standby), .link_fail(link_fail)
    );
    iocl_peer p (
        .clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_peer(tx_peer), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_src(rx_src), .rx_reply(rx_reply), .rx_edge_io4(rx_e4),
        .rx_values(rx_values), .rx_period_s(rx_per)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic rst();
        nrst = 1'b0;
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
    endtask
    task automatic wf(input int n);
        k = 0;
        while (p.frames < n && k < 3000) begin
            @(posedge clock);
            k++;
        end
    endtask
    task automatic cf(input logic [7:0] pe);
        for (int i = 0; i < e.size(); i++) begin
            `CHK(p.got[i], e[i])
            `CHK(p.dest[i], pe)
        end
        p.got.delete();
        p.dest.delete();
    endtask

    initial begin
        fork
            begin
                repeat (90000) @(posedge clock);
                err_total++;
                close_out();
            end
        join_none
        rst();
        `CHK({tx_valid, ack_tx, ser_tx_valid, link_fail, io_out}, 21'h0)
        foreach (rows[i]) begin
            @(negedge clock);
            dpeer = rows[i].pe;
            srd = rows[i].b;
            srv = 1'b1;
            @(negedge clock);
            `CHK({data_tx_valid, order_valid}, {rows[i].dv, ~rows[i].dv})
            `CHK(rows[i].dv ? {data_tx_data, data_tx_peer} : {order_data, dpeer}, {srd, dpeer})
            srv = 1'b0;
        end
        @(negedge clock);
        role = `IOCL_ROLE_CLIENT;
        lp = 1'b1;
        slow = 1'b1;
        rst();
        io_in = 9'h103;
        wf(1);
        e = '{own, `IOCL_CH_SEP, `IOCL_CH_DIG, `IOCL_CH_REPLY, 8'h01, 8'h03, 8'h01, `IOCL_CH_CR};
        cf(tele);
        p.send(1'b1, tele, 9'h0a5, 8'h00, 1'b0);
        @(posedge clock);
        #1;
        `CHK(io_out, 9'h0a5)
        `CHK(standby, 1'b1)
        wf(2);
        `CHK(k > 900 && k < 1200, 1'b1)
        cf(tele);
        @(negedge clock);
        role = `IOCL_ROLE_SERVER;
        own = 8'h55;
        io_in = 9'h1c4;
        slow = 1'b0;
        rst();
        repeat (300) @(negedge clock);
        `CHK(p.frames, 2)
        p.send(1'b0, 8'h21, 9'h1ff, 8'h01, 1'b1);
        @(posedge clock);
        #1;
        `CHK(io_out, 9'h1f7)
        wf(3);
        e = '{own, `IOCL_CH_SEP, `IOCL_CH_DIG, `IOCL_CH_REPLY, 8'h01, 8'hc4, `IOCL_CH_CR};
        cf(8'h21);
        // ten clients, the last one must stay untracked
        for (int s = 8'h22; s <= 8'h2a; s++)
            p.send(1'b0, s[7:0], 9'h1ff, 8'h01, 1'b0);
        k = 0;
        while (acks == 0 && k < 50000) begin
            @(posedge clock);
            k++;
        end
        `CHK(k > 29950 && k < 40010, 1'b1)
        repeat (11000) @(negedge clock);
        `CHK(acks, 9)
        `CHK(ser.size(), 63)
        e = '{`IOCL_CH_TWO, `IOCL_CH_FIVE, `IOCL_CH_FIVE, `IOCL_CH_SEP, `IOCL_CH_DIG,
              `IOCL_CH_ERR, `IOCL_CH_CR};
        foreach (e[i]) `CHK(ser[i], e[i])
        `CHK(link_fail, 9'h1ff)
        p.send(1'b0, 8'h21, 9'h1ff, 8'h01, 1'b0);
        @(posedge clock);
        #1;
        `CHK(link_fail, 9'h1fe)
        repeat (500) @(negedge clock);
        `CHK(acks, 9)
        close_out();
    end
endmodule
